/* File: rtl/mftr_defines.vh */
// Constants for the multifunction terminal routing block.
// Assumes inclusion by bare name from rtl/ sources.
`ifndef MFTR_DEFINES_VH
`define MFTR_DEFINES_VH

// Configuration space offset of the routing register
`define MFTR_ROUTE_OFFSET 8'h8C
// Reset value: all zero except the terminal 3 field, which is 0001
`define MFTR_ROUTE_RESET 32'h00001000
// Writable bits; bits 31..28 are read-only zero
`define MFTR_ROUTE_WMASK 32'h0FFFFFFF
// Field positions (low bit of each 4-bit field)
`define MFTR_T0_LSB 0
`define MFTR_T1_LSB 4
`define MFTR_T2_LSB 8
`define MFTR_T3_LSB 12
`define MFTR_T4_LSB 16
`define MFTR_T5_LSB 20
`define MFTR_T6_LSB 24
// Field codes
`define MFTR_C_GPI 4'h0
`define MFTR_C_GPO 4'h1
`define MFTR_C_ALT 4'h2
`define MFTR_C_ZVST 4'h6
`define MFTR_C_ZVSEL 4'h7
`define MFTR_C_PWM 4'h8
`define MFTR_C_CC 4'hC
`define MFTR_C_CD 4'hD
`define MFTR_C_CE 4'hE
`define MFTR_C_CF 4'hF

`endif

/* File: rtl/mftr_routing.v */
// Multifunction terminal routing register and terminal multiplexers.
// Assumes a decoded configuration-space access port from the PCI target
// and an EEPROM loader; all inputs are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "mftr_defines.vh"

module mftr_routing (
	input wire clk,
	input wire rst_n,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire cfg_func,
	input wire [7:0] cfg_addr,
	input wire [31:0] cfg_wdata,
	input wire [3:0] cfg_be,
	output reg [31:0] cfg_rdata_q,
	output reg cfg_hit_q,
	input wire eeprom_load,
	input wire [31:0] eeprom_data,
	input wire serial_bus_mode,
	input wire scl_drive_low,
	input wire sda_drive_low,
	output reg sda_in_q,
	input wire [15:0] isa_irq,
	input wire serial_interrupt_stream_out,
	input wire serial_interrupt_stream_oe,
	output reg serial_interrupt_stream_in_q,
	input wire clkrun_drive_low,
	output reg clkrun_in_n_q,
	output reg lock_in_n_q,
	input wire pci_inta_req,
	input wire pci_intb_req,
	input wire zoom_video_status,
	input wire zoom_function0_select,
	input wire zoom_function1_select,
	input wire card_audio_pwm,
	input wire socket0_activity_led,
	input wire socket1_activity_led,
	input wire ring_indicate_output,
	input wire general_event_output,
	input wire gp_output_zero,
	input wire gp_output_one,
	input wire gp_output_two,
	input wire gp_output_three,
	input wire gp_output_four,
	output reg gp_input_zero_q,
	output reg gp_input_one_q,
	output reg gp_input_two_q,
	output reg gp_input_three_q,
	output reg gp_input_four_q,
	input wire [6:0] term_in,
	output reg [6:0] term_out_q,
	output reg [6:0] term_oe_q,
	output reg [31:0] route_q
);

	wire [3:0] terminal0_select;
	wire [3:0] terminal1_select;
	wire [3:0] terminal2_select;
	wire [3:0] terminal3_select;
	wire [3:0] terminal4_select;
	wire [3:0] terminal5_select;
	wire [3:0] terminal6_select;
	wire cfg_hit;
	reg [31:0] route_d;
	reg [31:0] wr_bits;
	reg [6:0] out_d;
	reg [6:0] oe_d;

	// Codes 3,4,5,9,10,11,15 are the shared interrupt set
	function common_irq;
		input [3:0] code;
		begin
			case (code)
				4'h3, 4'h4, 4'h5, 4'h9, 4'hA, 4'hB, 4'hF: common_irq = 1'b1;
				default: common_irq = 1'b0;
			endcase
		end
	endfunction

	// Byte-enable expansion
	function [31:0] be_mask;
		input [3:0] be;
		begin
			be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		end
	endfunction

	assign terminal0_select = route_q[`MFTR_T0_LSB +: 4];
	assign terminal1_select = route_q[`MFTR_T1_LSB +: 4];
	assign terminal2_select = route_q[`MFTR_T2_LSB +: 4];
	assign terminal3_select = route_q[`MFTR_T3_LSB +: 4];
	assign terminal4_select = route_q[`MFTR_T4_LSB +: 4];
	assign terminal5_select = route_q[`MFTR_T5_LSB +: 4];
	assign terminal6_select = route_q[`MFTR_T6_LSB +: 4];

	// Same register is seen from either function
	assign cfg_hit = (cfg_addr == `MFTR_ROUTE_OFFSET);

	always @* begin
		wr_bits = be_mask(cfg_be) & `MFTR_ROUTE_WMASK;
		route_d = route_q;
		if (eeprom_load)
			route_d = eeprom_data & `MFTR_ROUTE_WMASK;
		else if (cfg_wr && cfg_hit)
			route_d = (route_q & ~wr_bits) | (cfg_wdata & wr_bits);
	end

	always @(posedge clk) begin
		if (!rst_n)
			route_q <= `MFTR_ROUTE_RESET;
		else
			route_q <= route_d;
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			cfg_rdata_q <= 32'h00000000;
			cfg_hit_q <= 1'b0;
		end else begin
			cfg_hit_q <= cfg_rd & cfg_hit;
			if (cfg_rd && cfg_hit)
				cfg_rdata_q <= route_q & `MFTR_ROUTE_WMASK;
			else
				cfg_rdata_q <= 32'h00000000;
		end
	end

	always @* begin
		out_d = 7'h00;
		oe_d = 7'h00;
		// Terminal 0
		case (terminal0_select)
			`MFTR_C_GPI: oe_d[0] = 1'b0;
			`MFTR_C_GPO: {oe_d[0], out_d[0]} = {1'b1, gp_output_zero};
			`MFTR_C_ALT: oe_d[0] = pci_inta_req;
			`MFTR_C_ZVST: {oe_d[0], out_d[0]} = {1'b1, zoom_video_status};
			`MFTR_C_ZVSEL:
				{oe_d[0], out_d[0]} = {1'b1, zoom_function0_select};
			`MFTR_C_PWM: {oe_d[0], out_d[0]} = {1'b1, card_audio_pwm};
			`MFTR_C_CC:
				{oe_d[0], out_d[0]} = {1'b1, socket0_activity_led};
			`MFTR_C_CD:
				{oe_d[0], out_d[0]} = {1'b1, socket1_activity_led};
			`MFTR_C_CE:
				{oe_d[0], out_d[0]} = {1'b1, general_event_output};
			default: {oe_d[0], out_d[0]} = {1'b1, isa_irq[terminal0_select]};
		endcase
		// Terminal 1; two-wire data in serial-bus mode
		if (serial_bus_mode) begin
			oe_d[1] = sda_drive_low;
		end else begin
			case (terminal1_select)
				`MFTR_C_GPI: oe_d[1] = 1'b0;
				`MFTR_C_GPO: {oe_d[1], out_d[1]} = {1'b1, gp_output_one};
				`MFTR_C_ALT: oe_d[1] = pci_intb_req;
				`MFTR_C_ZVST:
					{oe_d[1], out_d[1]} = {1'b1, zoom_video_status};
				`MFTR_C_ZVSEL:
					{oe_d[1], out_d[1]} = {1'b1, zoom_function0_select};
				`MFTR_C_PWM: {oe_d[1], out_d[1]} = {1'b1, card_audio_pwm};
				`MFTR_C_CC:
					{oe_d[1], out_d[1]} = {1'b1, socket0_activity_led};
				`MFTR_C_CD:
					{oe_d[1], out_d[1]} = {1'b1, socket1_activity_led};
				`MFTR_C_CE:
					{oe_d[1], out_d[1]} = {1'b1, general_event_output};
				default:
					{oe_d[1], out_d[1]} = {1'b1, isa_irq[terminal1_select]};
			endcase
		end
		// Terminal 2; code F is interrupt 7
		case (terminal2_select)
			`MFTR_C_GPI: oe_d[2] = 1'b0;
			`MFTR_C_GPO: {oe_d[2], out_d[2]} = {1'b1, gp_output_two};
			`MFTR_C_ALT: oe_d[2] = 1'b0;
			`MFTR_C_ZVST: {oe_d[2], out_d[2]} = {1'b1, zoom_video_status};
			`MFTR_C_ZVSEL:
				{oe_d[2], out_d[2]} = {1'b1, zoom_function0_select};
			`MFTR_C_PWM: {oe_d[2], out_d[2]} = {1'b1, card_audio_pwm};
			`MFTR_C_CC:
				{oe_d[2], out_d[2]} = {1'b1, ring_indicate_output};
			`MFTR_C_CD:
				{oe_d[2], out_d[2]} = {1'b1, socket1_activity_led};
			`MFTR_C_CE:
				{oe_d[2], out_d[2]} = {1'b1, general_event_output};
			`MFTR_C_CF: {oe_d[2], out_d[2]} = {1'b1, isa_irq[7]};
			default: {oe_d[2], out_d[2]} = {1'b1, isa_irq[terminal2_select]};
		endcase
		// Terminal 3
		case (terminal3_select)
			`MFTR_C_GPI: oe_d[3] = 1'b0;
			`MFTR_C_GPO: begin
				oe_d[3] = serial_interrupt_stream_oe;
				out_d[3] = serial_interrupt_stream_out;
			end
			default: {oe_d[3], out_d[3]} = {1'b1, isa_irq[terminal3_select]};
		endcase
		// Terminal 4; two-wire clock in serial-bus mode
		if (serial_bus_mode) begin
			oe_d[4] = scl_drive_low;
		end else if (common_irq(terminal4_select)) begin
			{oe_d[4], out_d[4]} = {1'b1, isa_irq[terminal4_select]};
		end else begin
			case (terminal4_select)
				`MFTR_C_GPO:
					{oe_d[4], out_d[4]} = {1'b1, gp_output_three};
				`MFTR_C_ZVST:
					{oe_d[4], out_d[4]} = {1'b1, zoom_video_status};
				`MFTR_C_ZVSEL:
					{oe_d[4], out_d[4]} = {1'b1, zoom_function1_select};
				`MFTR_C_PWM:
					{oe_d[4], out_d[4]} = {1'b1, card_audio_pwm};
				`MFTR_C_CC:
					{oe_d[4], out_d[4]} = {1'b1, ring_indicate_output};
				`MFTR_C_CD: begin
					oe_d[4] = 1'b1;
					out_d[4] = socket0_activity_led | socket1_activity_led;
				end
				`MFTR_C_CE:
					{oe_d[4], out_d[4]} = {1'b1, general_event_output};
				default: oe_d[4] = 1'b0;
			endcase
		end
		// Terminal 5
		if (common_irq(terminal5_select)) begin
			{oe_d[5], out_d[5]} = {1'b1, isa_irq[terminal5_select]};
		end else begin
			case (terminal5_select)
				`MFTR_C_GPO:
					{oe_d[5], out_d[5]} = {1'b1, gp_output_four};
				`MFTR_C_ZVST:
					{oe_d[5], out_d[5]} = {1'b1, zoom_video_status};
				`MFTR_C_ZVSEL:
					{oe_d[5], out_d[5]} = {1'b1, zoom_function1_select};
				`MFTR_C_PWM:
					{oe_d[5], out_d[5]} = {1'b1, card_audio_pwm};
				`MFTR_C_CC:
					{oe_d[5], out_d[5]} = {1'b1, socket0_activity_led};
				`MFTR_C_CD:
					{oe_d[5], out_d[5]} = {1'b1, general_event_output};
				default: oe_d[5] = 1'b0;
			endcase
		end
		// Terminal 6; clock-run is open drain
		case (terminal6_select)
			`MFTR_C_GPI: oe_d[6] = 1'b0;
			`MFTR_C_GPO: oe_d[6] = clkrun_drive_low;
			default: {oe_d[6], out_d[6]} = {1'b1, isa_irq[terminal6_select]};
		endcase
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			term_out_q <= 7'h00;
			term_oe_q <= 7'h00;
			gp_input_zero_q <= 1'b0;
			gp_input_one_q <= 1'b0;
			gp_input_two_q <= 1'b0;
			gp_input_three_q <= 1'b0;
			gp_input_four_q <= 1'b0;
			serial_interrupt_stream_in_q <= 1'b1;
			clkrun_in_n_q <= 1'b1;
			lock_in_n_q <= 1'b1;
			sda_in_q <= 1'b1;
		end else begin
			term_out_q <= out_d;
			term_oe_q <= oe_d;
			gp_input_zero_q <= (terminal0_select == `MFTR_C_GPI) & term_in[0];
			gp_input_one_q <= !serial_bus_mode &&
				(terminal1_select == `MFTR_C_GPI) && term_in[1];
			gp_input_two_q <= (terminal2_select == `MFTR_C_GPI) & term_in[2];
			gp_input_three_q <= !serial_bus_mode &&
				(terminal4_select == `MFTR_C_GPI) && term_in[4];
			gp_input_four_q <= (terminal5_select == `MFTR_C_GPI) & term_in[5];
			serial_interrupt_stream_in_q <=
				(terminal3_select == `MFTR_C_GPO) ? term_in[3] : 1'b1;
			clkrun_in_n_q <=
				(terminal6_select == `MFTR_C_GPO) ? term_in[6] : 1'b1;
			lock_in_n_q <= (!serial_bus_mode &&
				terminal4_select == `MFTR_C_ALT) ? term_in[4] : 1'b1;
			sda_in_q <= serial_bus_mode ? term_in[1] : 1'b1;
		end
	end

endmodule // mftr_routing

`default_nettype wire

/* File: tb/mftr_routing_properties.sv */
// Checker for the routing register port and the terminal decode.
// Assumes it is bound onto mftr_routing; one clock, sync low reset.
`timescale 1ns/100ps
`default_nettype none
module mftr_routing_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_rdata_q,
	input wire logic cfg_hit_q,
	input wire logic eeprom_load,
	input wire logic [31:0] eeprom_data,
	input wire logic serial_bus_mode,
	input wire logic scl_drive_low,
	input wire logic [15:0] isa_irq,
	input wire logic clkrun_drive_low,
	input wire logic [6:0] term_out_q,
	input wire logic [6:0] term_oe_q,
	input wire logic [31:0] route_q
);
	default clocking cb @(posedge clk);
	endclocking
	sequence s_rd_req;
		cfg_rd && cfg_addr == 8'h8C && !cfg_wr && !eeprom_load;
	endsequence
	sequence s_rd_ans;
		cfg_hit_q && cfg_rdata_q == ($past(route_q) & 32'h0FFFFFFF);
	endsequence
	property p_rd_hit;
		disable iff (!rst_n) s_rd_req |=> s_rd_ans;
	endproperty
	a_rd_hit: assert property (p_rd_hit)
		else $error("register read answer wrong");
	property p_rd_miss;
		disable iff (!rst_n) cfg_rd && cfg_addr != 8'h8C |=>
			!cfg_hit_q && cfg_rdata_q == 32'h0;
	endproperty
	a_rd_miss: assert property (p_rd_miss)
		else $error("unmapped read answered");
	property p_top_zero;
		disable iff (!rst_n) route_q[31:28] == 4'h0;
	endproperty
	a_top_zero: assert property (p_top_zero)
		else $error("read-only bits set");
	property p_eeprom;
		disable iff (!rst_n) eeprom_load |=>
			route_q == ($past(eeprom_data) & 32'h0FFFFFFF);
	endproperty
	a_eeprom: assert property (p_eeprom)
		else $error("load value not taken");
	property p_reset;
		!rst_n |=> route_q == 32'h00001000 && term_oe_q == 7'h00;
	endproperty
	a_reset: assert property (p_reset)
		else $error("reset state wrong");
	property p_t6_irq;
		disable iff (!rst_n) route_q[27:24] >= 4'h2 |=> term_oe_q[6] &&
			term_out_q[6] == $past(isa_irq[route_q[27:24]]);
	endproperty
	a_t6_irq: assert property (p_t6_irq)
		else $error("terminal 6 interrupt wrong");
	property p_t3_irq;
		disable iff (!rst_n) route_q[15:12] >= 4'h2 |=> term_oe_q[3] &&
			term_out_q[3] == $past(isa_irq[route_q[15:12]]);
	endproperty
	a_t3_irq: assert property (p_t3_irq)
		else $error("terminal 3 interrupt wrong");
	property p_t6_clkrun;
		disable iff (!rst_n) route_q[27:24] == 4'h1 |=>
			term_oe_q[6] == $past(clkrun_drive_low) && !term_out_q[6];
	endproperty
	a_t6_clkrun: assert property (p_t6_clkrun)
		else $error("clock-run drive wrong");
	property p_t5_reserved;
		disable iff (!rst_n)
			(route_q[23:20] == 4'h2 || route_q[23:20] == 4'hE) |=> !term_oe_q[5];
	endproperty
	a_t5_reserved: assert property (p_t5_reserved)
		else $error("reserved code drives terminal 5");
	property p_t4_scl;
		disable iff (!rst_n) serial_bus_mode |=>
			term_oe_q[4] == $past(scl_drive_low) && !term_out_q[4];
	endproperty
	a_t4_scl: assert property (p_t4_scl)
		else $error("serial clock drive wrong");
endmodule // mftr_routing_props
bind mftr_routing mftr_routing_props u_props (.clk, .rst_n, .cfg_wr, .cfg_rd,
	.cfg_addr, .cfg_rdata_q, .cfg_hit_q, .eeprom_load, .eeprom_data,
	.serial_bus_mode, .scl_drive_low, .isa_irq, .clkrun_drive_low,
	.term_out_q, .term_oe_q, .route_q);
`default_nettype wire

/* File: tb/tb_mftr_routing.sv */
// Self-checking bench for the routing register and terminal decode.
// Assumes rtl/ on the include path; inputs change at posedge by NBA.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_mftr_routing;
	logic clk = 0, rst_n = 0, cfg_wr = 0, cfg_rd = 0, cfg_func = 0;
	logic [7:0] cfg_addr = 8'h00;
	logic [31:0] cfg_wdata = 32'h0, eeprom_data = 32'h0, rd;
	logic [3:0] cfg_be = 4'h0;
	logic eeprom_load = 0, serial_bus_mode = 0, scl_drive_low = 0;
	logic [15:0] isa_irq = 16'h0;
	// Single-bit sources; 18:14 are the general-purpose outputs 4..0
	logic [18:0] src = 19'h0;
	logic [6:0] term_in = 7'h00;
	wire [31:0] cfg_rdata_q, route_q;
	wire [6:0] term_out_q, term_oe_q;
	wire cfg_hit_q, clkrun_in_n_q, lock_in_n_q;
	wire gp_input_three_q, gp_input_four_q;
	wire gp_input_zero_q, gp_input_one_q, gp_input_two_q;
	wire sda_in_q, serial_interrupt_stream_in_q;
	int n_errors = 0, n_tests = 0;
	mftr_routing DUT (.clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_func, .cfg_addr,
		.cfg_wdata, .cfg_be, .cfg_rdata_q, .cfg_hit_q, .eeprom_load,
		.eeprom_data, .serial_bus_mode, .scl_drive_low,
		.sda_drive_low(src[13]), .sda_in_q, .isa_irq,
		.serial_interrupt_stream_out(src[0]),
		.serial_interrupt_stream_oe(src[1]),
		.serial_interrupt_stream_in_q, .clkrun_drive_low(src[2]),
		.clkrun_in_n_q, .lock_in_n_q, .pci_inta_req(src[3]),
		.pci_intb_req(src[4]), .zoom_video_status(src[5]),
		.zoom_function0_select(src[6]), .zoom_function1_select(src[7]),
		.card_audio_pwm(src[8]), .socket0_activity_led(src[9]),
		.socket1_activity_led(src[10]), .ring_indicate_output(src[11]),
		.general_event_output(src[12]), .gp_output_zero(src[14]),
		.gp_output_one(src[15]), .gp_output_two(src[16]),
		.gp_output_three(src[17]), .gp_output_four(src[18]),
		.gp_input_zero_q, .gp_input_one_q, .gp_input_two_q,
		.gp_input_three_q, .gp_input_four_q, .term_in, .term_out_q,
		.term_oe_q, .route_q);
	always #2 clk = ~clk;
	// Alternates the function number so both functions are exercised
	task automatic cfg_write(input [7:0] a, input [31:0] d, input [3:0] be,
		input ld);
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_func <= ~cfg_func;
		cfg_addr <= a;
		cfg_wdata <= d;
		cfg_be <= be;
		eeprom_load <= ld;
		eeprom_data <= 32'hF5A5A5A5;
		@(posedge clk);
		cfg_wr <= 1'b0;
		eeprom_load <= 1'b0;
	endtask
	task automatic cfg_read(input [7:0] a, output [31:0] d, output h);
		@(posedge clk);
		cfg_rd <= 1'b1;
		cfg_addr <= a;
		@(posedge clk);
		cfg_rd <= 1'b0;
		#1;
		d = cfg_rdata_q;
		h = cfg_hit_q;
	endtask
	task automatic drive(input [15:0] irq, input [18:0] s);
		@(posedge clk);
		isa_irq <= irq;
		src <= s;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// Expected {skip, oe, out} of terminal 5 (t5) or terminal 4
	function automatic [2:0] exp_pin(input [3:0] c, input t5);
		case (c)
			4'h0: exp_pin = 3'b000;
			4'h1: exp_pin = {2'b01, t5 ? src[18] : src[17]};
			4'h2: exp_pin = 3'b000;
			4'h6: exp_pin = {2'b01, src[5]};
			4'h7: exp_pin = {2'b01, src[7]};
			4'h8: exp_pin = {2'b01, src[8]};
			4'hC: exp_pin = {2'b01, t5 ? src[9] : src[11]};
			4'hD: exp_pin = {2'b01, t5 ? src[12] : src[9] | src[10]};
			4'hE: exp_pin = t5 ? 3'b000 : {2'b01, src[12]};
			default: exp_pin = {2'b01, isa_irq[c]};
		endcase
	endfunction
	task automatic chk_pin(input int p, input [2:0] e);
		if (!e[2]) begin
			`CHK("term_oe", e[1], term_oe_q[p])
			if (e[1]) `CHK("term_out", e[0], term_out_q[p])
		end
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge clk);
		n_errors++;
		wrap_up;
	end
	initial begin
		int c, v;
		logic h;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		term_in <= 7'h37;
		cfg_read(8'h8C, rd, h);
		`CHK("reset value", 32'h00001000, rd)
		`CHK("hit", 1'b1, h)
		`CHK("pins idle", 7'h00, term_oe_q)
		`CHK("gp in", 2'b11, {gp_input_four_q, gp_input_three_q})
		`CHK("gp in low", 3'h7,
			{gp_input_two_q, gp_input_one_q, gp_input_zero_q})
		`CHK("serial irq in", 1'b0, serial_interrupt_stream_in_q)
		cfg_write(8'h8C, 32'hFFFFFFFF, 4'hF, 1'b0);
		cfg_read(8'h8C, rd, h);
		`CHK("top bits", 32'h0FFFFFFF, rd)
		cfg_write(8'h8C, 32'h00AB0000, 4'h4, 1'b0);
		cfg_write(8'h90, 32'h0, 4'hF, 1'b0);
		cfg_read(8'h8C, rd, h);
		`CHK("byte lane", 32'h0FABFFFF, rd)
		cfg_read(8'h90, rd, h);
		`CHK("unmapped", 33'h0, {h, rd})
		cfg_write(8'h8C, 32'h0, 4'hF, 1'b1);
		cfg_read(8'h8C, rd, h);
		`CHK("load", 32'h05A5A5A5, rd)
		for (c = 2; c < 16; c++) begin
			cfg_write(8'h8C, {4'h0, c[3:0], 8'h00, c[3:0], 12'h000}, 4'hF, 1'b0);
			for (v = 0; v < 2; v++) begin
				drive(v ? ~(16'h1 << c) : 16'h1 << c, 19'h0);
				`CHK("t6 irq", {1'b1, v == 0}, {term_oe_q[6], term_out_q[6]})
				`CHK("t3 irq", {1'b1, v == 0}, {term_oe_q[3], term_out_q[3]})
			end
		end
		cfg_write(8'h8C, 32'h01001000, 4'hF, 1'b0);
		drive(16'h0, 19'h00007);
		`CHK("clkrun", 2'b10, {term_oe_q[6], term_out_q[6]})
		`CHK("clkrun in", 1'b0, clkrun_in_n_q)
		`CHK("serial irq", 2'b11, {term_oe_q[3], term_out_q[3]})
		@(posedge clk);
		serial_bus_mode <= 1'b1;
		scl_drive_low <= 1'b1;
		term_in <= 7'h35;
		drive(16'h0, 19'h02000);
		`CHK("scl", 2'b10, {term_oe_q[4], term_out_q[4]})
		`CHK("sda", 3'b100, {term_oe_q[1], term_out_q[1], sda_in_q})
		`CHK("gp in 3 gated", 1'b0, gp_input_three_q)
		@(posedge clk);
		serial_bus_mode <= 1'b0;
		term_in <= 7'h25;
		for (c = 0; c < 16; c++) begin
			cfg_write(8'h8C, {8'h00, c[3:0], c[3:0], 16'h1000}, 4'hF, 1'b0);
			for (v = 0; v < 3; v++) begin
				case (v)
					0: drive(16'h8A28, 19'h55555);
					1: drive(16'h75D7, 19'h2AAAA);
					default: drive(16'h0000, 19'h00000);
				endcase
				chk_pin(5, exp_pin(c[3:0], 1'b1));
				chk_pin(4, exp_pin(c[3:0], 1'b0));
				`CHK("lock in", c == 2 ? term_in[4] : 1'b1, lock_in_n_q)
				`CHK("gp in 4", c == 0 ? term_in[5] : 1'b0, gp_input_four_q)
			end
		end
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		cfg_read(8'h8C, rd, h);
		`CHK("second reset", 32'h00001000, rd)
		`CHK("pins idle again", 7'h00, term_oe_q)
		wrap_up;
	end
endmodule // tb_mftr_routing
`default_nettype wire
